// ===== hw/bfsm_pkg.sv
// Shared constants, types and field helpers for the field and string merge unit
package bfsm_pkg;
   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0]  OP_BIT_COMPRESS = 8'h14;
   localparam logic [7:0]  OP_BIT_MERGE    = 8'h15;
   localparam logic [7:0]  OP_BIT_MASK     = 8'h16;
   localparam logic [7:0]  OP_STR_MERGE    = 8'h17;

   // ----------------------------------------------------------------
   // Field layout (bit 0 leftmost means MSB in these vectors)
   // ----------------------------------------------------------------
   localparam int          LEN_HI   = 63;
   localparam int          LEN_LO   = 48;
   localparam int          ADR_HI   = 47;
   localparam int          ADR_LO   = 0;
   localparam int          IW_OP_HI = 31;
   localparam int          IW_OP_LO = 24;
   localparam int          IW_R_HI  = 23;
   localparam int          IW_R_LO  = 16;
   localparam int          IW_S_HI  = 15;
   localparam int          IW_S_LO  = 8;
   localparam int          IW_T_HI  = 7;
   localparam int          IW_T_LO  = 0;
   localparam logic [2:0]  BYTE_MSB = 3'h7;
   localparam int          BIT_SH   = 3;

   localparam logic [15:0] LEN_ZERO = 16'h0000;
   localparam logic [15:0] LEN_ONE  = 16'h0001;
   localparam logic [47:0] ADR_ZERO = 48'h0000_0000_0000;
   localparam logic [47:0] ADR_ONE  = 48'h0000_0000_0001;

   // ----------------------------------------------------------------
   // Memory access commands
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_RD_BIT,
      CMD_WR_BIT,
      CMD_RD_BYTE,
      CMD_WR_BYTE
   } bfsm_cmd_t;

   function automatic logic [15:0] bfsm_len(input logic [63:0] r);
      return r[LEN_HI:LEN_LO];
   endfunction : bfsm_len

   function automatic logic [47:0] bfsm_adr(input logic [63:0] r);
      return r[ADR_HI:ADR_LO];
   endfunction : bfsm_adr

   function automatic logic [47:0] bfsm_zx(input logic [15:0] v);
      return {32'h0000_0000, v};
   endfunction : bfsm_zx
endpackage : bfsm_pkg

// ===== hw/bfsm_acc_if.sv
// Access channel between the sequencer and the memory port
interface bfsm_acc_if;
   import bfsm_pkg::*;
   logic        req;
   bfsm_cmd_t   cmd;
   logic [47:0] addr;
   logic        wbit;
   logic [7:0]  wbyte;
   logic        done;
   logic        rbit;
   logic [7:0]  rbyte;

   modport eng  (output req, cmd, addr, wbit, wbyte, input done, rbit, rbyte);
   modport port (input req, cmd, addr, wbit, wbyte, output done, rbit, rbyte);
endinterface : bfsm_acc_if

// ===== hw/bfsm_mem_port.sv
// Bit and byte memory port with read-modify-write for single bits
module bfsm_mem_port
   import bfsm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   bfsm_acc_if.port         acc,
   output      logic        mem_req,
   output      logic        mem_we,
   output      logic [47:0] mem_addr,
   output      logic [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {P_IDLE, P_RD, P_WR} bfsm_pst_t;

   typedef struct packed {
      bfsm_pst_t   st;
      bfsm_cmd_t   cmd;
      logic [2:0]  bitpos;
      logic        wbit;
      logic        mreq;
      logic        mwe;
      logic [47:0] maddr;
      logic [7:0]  mwdata;
      logic        done;
      logic        rbit;
      logic [7:0]  rbyte;
   } bfsm_port_t;

   bfsm_port_t s;
   bfsm_port_t next_s;
   logic [2:0] lane;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      lane        = BYTE_MSB - s.bitpos;
      case (s.st)
         P_IDLE: begin
            if (acc.req) begin
               next_s.cmd    = acc.cmd;
               next_s.bitpos = acc.addr[BIT_SH-1:0];
               next_s.wbit   = acc.wbit;
               next_s.mreq   = 1'b1;
               next_s.mwdata = acc.wbyte;
               if (acc.cmd == CMD_RD_BIT || acc.cmd == CMD_WR_BIT) begin
                  next_s.maddr = acc.addr >> BIT_SH;
               end else begin
                  next_s.maddr = acc.addr;
               end
               // Whole bytes are written blind, single bits need the old byte
               next_s.mwe = (acc.cmd == CMD_WR_BYTE);
               next_s.st  = (acc.cmd == CMD_WR_BYTE) ? P_WR : P_RD;
            end
         end
         P_RD: begin
            if (mem_ack) begin
               next_s.rbyte = mem_rdata;
               next_s.rbit  = mem_rdata[lane];
               if (s.cmd == CMD_WR_BIT) begin
                  next_s.mwdata       = mem_rdata;
                  next_s.mwdata[lane] = s.wbit;
                  next_s.mwe          = 1'b1;
                  next_s.st           = P_WR;
               end else begin
                  next_s.mreq = 1'b0;
                  next_s.done = 1'b1;
                  next_s.st   = P_IDLE;
               end
            end
         end
         P_WR: begin
            if (mem_ack) begin
               next_s.mreq = 1'b0;
               next_s.mwe  = 1'b0;
               next_s.done = 1'b1;
               next_s.st   = P_IDLE;
            end
         end
         default: next_s.st = P_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign mem_req   = s.mreq;
   assign mem_we    = s.mwe;
   assign mem_addr  = s.maddr;
   assign mem_wdata = s.mwdata;
   assign acc.done  = s.done;
   assign acc.rbit  = s.rbit;
   assign acc.rbyte = s.rbyte;
endmodule : bfsm_mem_port

// ===== hw/bfsm_unit.sv
// Sequencer for bit compress, bit merge, bit mask and string merge
// What this block does
// - Compress: R length high, bit address low
// - Compress: skip length from S high bits
// - T gives destination length and base
// - Copy R segment, then skip S segment
// - Compress stops when destination is full
// - Compress no-op on zero R or T
// - Merge alternates R and S segments
// - Merge writes zeros when S address zero
// - Merge no-op on any zero length
// - Mask S segment offset by R length
// - Mask sources advance by both lengths
// - Mask zero S, zero no-op, fill
// - String: T record bytes and base
// - String: sources give count and base
// - Exhausted source: copy the rest
// - String no-op: zero record or counts
// - Records compared bytewise as unsigned
module bfsm_unit
   import bfsm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic [31:0] instr,
   output      logic [7:0]  sel_r,
   output      logic [7:0]  sel_s,
   output      logic [7:0]  sel_t,
   input  wire logic [63:0] op_r,
   input  wire logic [63:0] op_s,
   input  wire logic [63:0] op_t,
   output      logic        busy,
   output      logic        done,
   output      logic        mem_req,
   output      logic        mem_we,
   output      logic [47:0] mem_addr,
   output      logic [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_LOAD, S_BIT_RD, S_BIT_WR,
      S_CMP_R, S_CMP_S, S_CPY_RD, S_CPY_WR, S_DONE
   } bfsm_st_t;

   typedef struct packed {
      bfsm_st_t    st;
      logic [7:0]  op;
      logic [7:0]  sel_r;
      logic [7:0]  sel_s;
      logic [7:0]  sel_t;
      logic [15:0] rlen;
      logic [15:0] slen;
      logic [15:0] tlen;
      logic [15:0] seg;
      logic [15:0] rcnt;
      logic [15:0] scnt;
      logic [15:0] idx;
      logic [47:0] ra;
      logic [47:0] sa;
      logic [47:0] ta;
      logic        phase_b;
      logic        szero;
      logic        pick_s;
      logic [7:0]  rbyte;
      logic        req;
      bfsm_cmd_t   cmd;
      logic [47:0] addr;
      logic        wbit;
      logic [7:0]  wbyte;
      logic        done;
   } bfsm_state_t;

   bfsm_state_t s;
   bfsm_state_t next_s;

   bfsm_acc_if acc ();

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic bfsm_state_t issue(input bfsm_state_t x, input bfsm_cmd_t c,
                                         input logic [47:0] a, input bfsm_st_t w);
      bfsm_state_t y;
      y      = x;
      y.req  = 1'b1;
      y.cmd  = c;
      y.addr = a;
      y.st   = w;
      return y;
   endfunction : issue

   // Fetch the next destination bit from whichever source owns the segment
   function automatic bfsm_state_t bit_fetch(input bfsm_state_t x);
      bfsm_state_t y;
      y = x;
      if (x.phase_b && x.szero) begin
         y.wbit = 1'b0;
         y      = issue(y, CMD_WR_BIT, x.ta, S_BIT_WR);
      end else if (x.phase_b) begin
         y = issue(y, CMD_RD_BIT, x.sa, S_BIT_RD);
      end else begin
         y = issue(y, CMD_RD_BIT, x.ra, S_BIT_RD);
      end
      return y;
   endfunction : bit_fetch

   // Pick the next record: compare while both strings last, else drain
   function automatic bfsm_state_t next_record(input bfsm_state_t x);
      bfsm_state_t y;
      y     = x;
      y.idx = LEN_ZERO;
      if (x.rcnt != LEN_ZERO && x.scnt != LEN_ZERO) begin
         y = issue(y, CMD_RD_BYTE, x.ra, S_CMP_R);
      end else if (x.rcnt != LEN_ZERO) begin
         y.pick_s = 1'b0;
         y        = issue(y, CMD_RD_BYTE, x.ra, S_CPY_RD);
      end else if (x.scnt != LEN_ZERO) begin
         y.pick_s = 1'b1;
         y        = issue(y, CMD_RD_BYTE, x.sa, S_CPY_RD);
      end else begin
         y.st = S_DONE;
      end
      return y;
   endfunction : next_record

   function automatic logic [47:0] cpy_src(input bfsm_state_t x, input logic [15:0] i);
      return (x.pick_s ? x.sa : x.ra) + bfsm_zx(i);
   endfunction : cpy_src

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.req  = 1'b0;
      next_s.done = 1'b0;
      case (s.st)
         S_IDLE: begin
            if (start) begin
               next_s.op    = instr[IW_OP_HI:IW_OP_LO];
               next_s.sel_r = instr[IW_R_HI:IW_R_LO];
               next_s.sel_s = instr[IW_S_HI:IW_S_LO];
               next_s.sel_t = instr[IW_T_HI:IW_T_LO];
               next_s.st    = S_LOAD;
            end
         end
         S_LOAD: begin
            next_s.rlen    = bfsm_len(op_r);
            next_s.ra      = bfsm_adr(op_r);
            next_s.slen    = bfsm_len(op_s);
            next_s.sa      = bfsm_adr(op_s);
            next_s.tlen    = bfsm_len(op_t);
            next_s.ta      = bfsm_adr(op_t);
            next_s.szero   = (bfsm_adr(op_s) == ADR_ZERO);
            next_s.seg     = bfsm_len(op_r);
            next_s.phase_b = 1'b0;
            next_s.rcnt    = bfsm_len(op_r);
            next_s.scnt    = bfsm_len(op_s);
            next_s.st      = S_DONE;
            case (s.op)
               OP_BIT_COMPRESS: begin
                  if (bfsm_len(op_r) != LEN_ZERO && bfsm_len(op_t) != LEN_ZERO) begin
                     next_s = bit_fetch(next_s);
                  end
               end
               OP_BIT_MERGE, OP_BIT_MASK: begin
                  // The mask form starts its S stream one R length in
                  if (s.op == OP_BIT_MASK) begin
                     next_s.sa = bfsm_adr(op_s) + bfsm_zx(bfsm_len(op_r));
                  end
                  if (bfsm_len(op_r) != LEN_ZERO && bfsm_len(op_s) != LEN_ZERO
                      && bfsm_len(op_t) != LEN_ZERO) begin
                     next_s = bit_fetch(next_s);
                  end
               end
               OP_STR_MERGE: begin
                  next_s.rlen = bfsm_len(op_t);
                  if (bfsm_len(op_t) != LEN_ZERO) begin
                     next_s = next_record(next_s);
                  end
               end
               default: next_s.st = S_DONE;
            endcase
         end
         S_BIT_RD: begin
            if (acc.done) begin
               next_s.wbit = acc.rbit;
               if (s.phase_b) begin
                  next_s.sa = s.sa + ADR_ONE;
               end else begin
                  next_s.ra = s.ra + ADR_ONE;
               end
               next_s = issue(next_s, CMD_WR_BIT, s.ta, S_BIT_WR);
            end
         end
         S_BIT_WR: begin
            if (acc.done) begin
               next_s.ta   = s.ta + ADR_ONE;
               next_s.tlen = s.tlen - LEN_ONE;
               next_s.seg  = s.seg - LEN_ONE;
               if (s.tlen == LEN_ONE) begin
                  next_s.st = S_DONE;
               end else begin
                  if (s.seg == LEN_ONE) begin
                     case (s.op)
                        OP_BIT_COMPRESS: begin
                           next_s.ra  = s.ra + bfsm_zx(s.slen);
                           next_s.seg = s.rlen;
                        end
                        OP_BIT_MASK: begin
                           if (s.phase_b) begin
                              next_s.sa = s.sa + bfsm_zx(s.rlen);
                           end else begin
                              next_s.ra = s.ra + bfsm_zx(s.slen);
                           end
                           next_s.phase_b = !s.phase_b;
                           next_s.seg     = s.phase_b ? s.rlen : s.slen;
                        end
                        default: begin
                           next_s.phase_b = !s.phase_b;
                           next_s.seg     = s.phase_b ? s.rlen : s.slen;
                        end
                     endcase
                  end
                  next_s = bit_fetch(next_s);
               end
            end
         end
         S_CMP_R: begin
            if (acc.done) begin
               next_s.rbyte = acc.rbyte;
               next_s = issue(next_s, CMD_RD_BYTE, s.sa + bfsm_zx(s.idx), S_CMP_S);
            end
         end
         S_CMP_S: begin
            if (acc.done) begin
               // Unsigned byte order from the left decides the record order
               if (s.rbyte < acc.rbyte) begin
                  next_s.pick_s = 1'b0;
                  next_s.idx    = LEN_ZERO;
                  next_s = issue(next_s, CMD_RD_BYTE, s.ra, S_CPY_RD);
               end else if (s.rbyte > acc.rbyte) begin
                  next_s.pick_s = 1'b1;
                  next_s.idx    = LEN_ZERO;
                  next_s = issue(next_s, CMD_RD_BYTE, s.sa, S_CPY_RD);
               end else if (s.idx == s.rlen - LEN_ONE) begin
                  next_s.pick_s = 1'b0;
                  next_s.idx    = LEN_ZERO;
                  next_s = issue(next_s, CMD_RD_BYTE, s.ra, S_CPY_RD);
               end else begin
                  next_s.idx = s.idx + LEN_ONE;
                  next_s = issue(next_s, CMD_RD_BYTE, s.ra + bfsm_zx(next_s.idx), S_CMP_R);
               end
            end
         end
         S_CPY_RD: begin
            if (acc.done) begin
               next_s.wbyte = acc.rbyte;
               next_s = issue(next_s, CMD_WR_BYTE, s.ta, S_CPY_WR);
            end
         end
         S_CPY_WR: begin
            if (acc.done) begin
               next_s.ta  = s.ta + ADR_ONE;
               next_s.idx = s.idx + LEN_ONE;
               if (s.idx == s.rlen - LEN_ONE) begin
                  // Record finished: step its source past it, then pick the next record
                  if (s.pick_s) begin
                     next_s.sa   = s.sa + bfsm_zx(s.rlen);
                     next_s.scnt = s.scnt - LEN_ONE;
                  end else begin
                     next_s.ra   = s.ra + bfsm_zx(s.rlen);
                     next_s.rcnt = s.rcnt - LEN_ONE;
                  end
                  next_s = next_record(next_s);
               end else begin
                  next_s = issue(next_s, CMD_RD_BYTE, cpy_src(s, next_s.idx), S_CPY_RD);
               end
            end
         end
         S_DONE: begin
            next_s.done = 1'b1;
            next_s.st   = S_IDLE;
         end
         default: next_s.st = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Memory port
   // ----------------------------------------------------------------
   assign acc.req   = s.req;
   assign acc.cmd   = s.cmd;
   assign acc.addr  = s.addr;
   assign acc.wbit  = s.wbit;
   assign acc.wbyte = s.wbyte;

   // One access at a time keeps the port simple at the cost of throughput
   bfsm_mem_port u_port (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .acc       (acc),
      .mem_req   (mem_req),
      .mem_we    (mem_we),
      .mem_addr  (mem_addr),
      .mem_wdata (mem_wdata),
      .mem_rdata (mem_rdata),
      .mem_ack   (mem_ack)
   );

   assign sel_r = s.sel_r;
   assign sel_s = s.sel_s;
   assign sel_t = s.sel_t;
   assign busy  = (s.st != S_IDLE);
   assign done  = s.done;
endmodule : bfsm_unit

// ===== test/bfsm_unit_sva.sv
// Port checks for the field and string merge unit
module bfsm_unit_sva
   import bfsm_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        start,
   input wire logic [31:0] instr,
   input wire logic [7:0]  sel_r,
   input wire logic [7:0]  sel_s,
   input wire logic [7:0]  sel_t,
   input wire logic [63:0] op_t,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [47:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take;
   assign take = start && !busy && ce;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   a_start_busy: assert property (take |=> busy)
      else $error("start not taken while idle");
   a_sel_latch: assert property (take |=> {sel_r, sel_s, sel_t} == $past(instr[23:0]))
      else $error("designators not latched");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_done_idle: assert property (done |-> !busy && !mem_req)
      else $error("done while busy");
   // Memory contract: the request is held whole until the ack edge
   a_req_hold: assert property (mem_req && !mem_ack |=>
      mem_req && $stable({mem_we, mem_addr, mem_wdata}))
      else $error("request changed before ack");
   a_wr_release: assert property (mem_ack && mem_we |=> !mem_req)
      else $error("request kept after write ack");
   a_req_busy: assert property (mem_req |-> busy)
      else $error("memory request while idle");
   a_noop_quick: assert property (take ##1 (op_t[63:48] == 16'h0000) |->
      !mem_req throughout (##[1:3] done))
      else $error("zero length did not finish at once");
endmodule : bfsm_unit_sva

// ===== test/bfsm_mem_model.sv
// Byte memory on the far side, answering promptly or after random waits
module bfsm_mem_model (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [47:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output      logic [7:0]  mem_rdata,
   output      logic        mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [47:0]];
   // Read data toggles outside the ack cycle so stale bytes never look valid
   always @(posedge mclk) begin
      if (rst) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 8'hA5;
      end else if (mem_ack || !mem_req || (slow && $urandom_range(3) != 0)) begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else begin
         mem_ack <= 1'b1;
         if (mem_we)
            mem[mem_addr] = mem_wdata;
         else
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
      end
   end
endmodule : bfsm_mem_model

// ===== test/bfsm_unit_bench.sv
// Random and corner-case bench for the field and string merge unit
module bfsm_unit_bench
   import bfsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk  = 1'b0;
   logic        rst   = 1'b1;
   logic        ce    = 1'b1;
   logic        start = 1'b0;
   logic        slow  = 1'b0;
   logic [31:0] instr = 32'h0000_0000;
   logic [7:0]  sel_r, sel_s, sel_t, mem_rdata, mem_wdata, v, e;
   logic [63:0] op_r, op_s, op_t, rr, ss, tt;
   logic        busy, done, mem_req, mem_we, mem_ack;
   logic [47:0] mem_addr;
   logic [63:0] rf [256];
   logic [7:0]  ref_m [logic [47:0]];
   logic [7:0]  ops [5] = '{OP_BIT_COMPRESS, OP_BIT_MERGE, OP_BIT_MASK, OP_STR_MERGE, 8'h3C};
   int          error_cnt = 0;
   int          compares  = 0;

   always #5 mclk = ~mclk;
   assign op_r = rf[sel_r];
   assign op_s = rf[sel_s];
   assign op_t = rf[sel_t];

   bfsm_unit i_bfsm_unit (.mclk(mclk), .rst(rst), .ce(ce), .start(start), .instr(instr),
      .sel_r(sel_r), .sel_s(sel_s), .sel_t(sel_t), .op_r(op_r), .op_s(op_s), .op_t(op_t),
      .busy(busy), .done(done), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   bfsm_mem_model i_bfsm_mem_model (.mclk(mclk), .rst(rst), .slow(slow), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   // ------------------------------------------------
   // Expected memory image
   // ------------------------------------------------
   function automatic void cp(inout logic [47:0] src, inout logic [47:0] dst, inout int n,
                              input int len, input bit zero);
      for (int i = 0; i < len && n > 0; i++) begin
         ref_m[dst >> 3][3'h7 - dst[2:0]] = zero ? 1'b0 : ref_m[src >> 3][3'h7 - src[2:0]];
         src++;
         dst++;
         n--;
      end
   endfunction : cp

   function automatic void predict(input logic [7:0] op);
      logic [47:0] pr, ps, pt;
      int          n, rl, sl;
      bit          take_s;
      rl = int'(rr[63:48]);
      sl = int'(ss[63:48]);
      n  = int'(tt[63:48]);
      pr = rr[47:0];
      ps = (op == OP_BIT_MASK) ? ss[47:0] + 48'(rl) : ss[47:0];
      pt = tt[47:0];
      if (op == OP_BIT_COMPRESS && rl != 0)
         while (n > 0) begin
            cp(pr, pt, n, rl, 1'b0);
            pr = pr + 48'(sl);
         end
      if ((op == OP_BIT_MERGE || op == OP_BIT_MASK) && rl != 0 && sl != 0)
         while (n > 0) begin
            cp(pr, pt, n, rl, 1'b0);
            cp(ps, pt, n, sl, ss[47:0] == 48'h0);
            if (op == OP_BIT_MASK) begin
               pr = pr + 48'(sl);
               ps = ps + 48'(rl);
            end
         end
      if (op == OP_STR_MERGE && n != 0)
         while (rl + sl > 0) begin
            take_s = (rl == 0);
            if (rl != 0 && sl != 0)
               for (int k = n - 1; k >= 0; k--)
                  if (ref_m[pr + k] != ref_m[ps + k])
                     take_s = ref_m[ps + k] < ref_m[pr + k];
            for (int k = 0; k < n; k++)
               ref_m[pt + k] = take_s ? ref_m[ps + k] : ref_m[pr + k];
            pt = pt + 48'(n);
            if (take_s) begin
               ps = ps + 48'(n);
               sl--;
            end else begin
               pr = pr + 48'(n);
               rl--;
            end
         end
   endfunction : predict

   task automatic run(input logic [7:0] op);
      logic [31:0] iw;
      int          w;
      iw = {op, 8'($urandom_range(85, 1)), 8'($urandom_range(170, 86)),
            8'($urandom_range(255, 171))};
      rf[iw[23:16]] = rr;
      rf[iw[15:8]]  = ss;
      rf[iw[7:0]]   = tt;
      // String merge gets two byte values only, so equal records and the high bit both turn up often
      for (int a = 0; a < 256; a++) begin
         v = (op == OP_STR_MERGE) ? 8'h41 + 8'h80 * 8'($urandom_range(1)) : 8'($urandom);
         i_bfsm_mem_model.mem[48'(a)] = v;
         ref_m[48'(a)] = v;
      end
      predict(op);
      slow  = 1'($urandom_range(1));
      ce    = 1'b0;
      start = 1'b1;
      instr = iw;
      repeat (2) @(posedge mclk);
      #1 chk("busy frozen", busy, 64'h0);
      ce = 1'b1;
      @(posedge mclk);
      #1 start = 1'b0;
      chk("busy", busy, 64'h1);
      chk("designators", {sel_r, sel_s, sel_t}, iw[23:0]);
      w = 0;
      while (done !== 1'b1 && w < 5000) begin
         @(posedge mclk);
         #1 w++;
      end
      chk("done", done, 64'h1);
      for (int a = 0; a < 256; a++) begin
         v = i_bfsm_mem_model.mem[48'(a)];
         e = ref_m[48'(a)];
         case (op)
            OP_BIT_COMPRESS: chk("compress", v, e);
            OP_BIT_MERGE:    chk("merge", v, e);
            OP_BIT_MASK:     chk("mask", v, e);
            OP_STR_MERGE:    chk("string", v, e);
            default:         chk("unused opcode", v, e);
         endcase
      end
      @(posedge mclk);
      #1;
   endtask : run

   initial begin
      logic [7:0] op;
      void'($urandom(69935));
      for (int i = 0; i < 256; i++)
         rf[i] = 64'h0;
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      for (int i = 0; i < 40; i++) begin
         op = ops[i % 5];
         if (op == OP_STR_MERGE) begin
            rr = {16'($urandom_range(6)), 48'($urandom_range(7))};
            ss = {16'($urandom_range(6)), 48'(64 + $urandom_range(7))};
            tt = {16'(1 + $urandom_range(2)), 48'(128 + $urandom_range(7))};
         end else begin
            rr = {16'(1 + $urandom_range(5)), 48'($urandom_range(63))};
            ss = {16'(1 + $urandom_range(5)), 48'(512 + $urandom_range(63))};
            tt = {16'(1 + $urandom_range(31)), 48'(1024 + $urandom_range(63))};
         end
         case (i)
            5, 12:  rr[63:48] = 16'h0000;
            6, 7:   ss[47:0] = 48'h0;
            8:      {rr[63:48], ss[63:48]} = 32'h0;
            10, 13: tt[63:48] = 16'h0000;
            11:     ss[63:48] = 16'h0000;
            18:     rr[63:48] = 16'h0000;
            default: ;
         endcase
         run(op);
         $display("Test %0d opcode %h finished, mismatches %0d", i, op, error_cnt);
      end
      end_sim();
   end

   // Forty instructions need well under half of this span
   initial begin
      #600_000;
      $display("Watchdog expired");
      error_cnt++;
      end_sim();
   end
endmodule : bfsm_unit_bench

bind bfsm_unit bfsm_unit_sva i_bfsm_unit_sva (.mclk(mclk), .rst(rst), .ce(ce), .start(start),
   .instr(instr), .sel_r(sel_r), .sel_s(sel_s), .sel_t(sel_t), .op_t(op_t), .busy(busy),
   .done(done), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .mem_ack(mem_ack));
